// ===== dpn_defs.svh
// constants for the dual pseudo-noise sequence source
`ifndef DPN_DEFS_SVH
`define DPN_DEFS_SVH
// ----------------------------------------------------------------
// sequence store geometry
// ----------------------------------------------------------------
`define DPN_NUM_POS 10
`define DPN_POS_W 4
`define DPN_ADDR_W 14
`define DPN_LAST_POS 4'h9
`define DPN_POS_ZERO 4'h0
`define DPN_POS_ONE 4'h1
// ----------------------------------------------------------------
// period lengths and default fill polynomials
// ----------------------------------------------------------------
`define DPN_LONG_LEN 14'h3FFF
`define DPN_SHORT_LEN 14'h007F
`define DPN_LONG_MASK 14'h3802
`define DPN_SHORT_MASK 7'h60
`define DPN_ADDR_ZERO 14'h0000
`define DPN_ADDR_ONE 14'h0001
// ----------------------------------------------------------------
// bipolar output codes, two's complement volts
// ----------------------------------------------------------------
`define DPN_LEVEL_NEG 3'h6
`define DPN_LEVEL_POS 3'h2
// ----------------------------------------------------------------
// pin synchroniser layout
// ----------------------------------------------------------------
`define DPN_SYNC_W 9
`define DPN_SB_CLK 8
`define DPN_SB_RST 7
`define DPN_SB_BTN 6
`define DPN_SB_SEL_HI 5
`define DPN_SB_SEL_LO 2
`define DPN_SB_XA 1
`define DPN_SB_XB 0
`endif

// ===== dpn_pkg.sv
// types shared by the dual pseudo-noise sequence source
package dpn_pkg;
  // one chip leaving a generator
  typedef struct packed {
    logic seq;
    logic mark;
  } dpn_chip_s;
  // default-fill and run phases
  typedef enum logic [1:0] {
    DPN_ST_FILL = 2'b01,
    DPN_ST_RUN = 2'b10
  } dpn_phase_e;
  // signed bipolar level code
  typedef logic [2:0] dpn_level_t;
endpackage

// ===== dpn_source.sv
// dual pseudo-noise sequence source with paired exclusive-or units
`timescale 1ns/1ps
`include "dpn_defs.svh"

module dpn_source #(
  parameter logic [`DPN_ADDR_W-1:0] LONG_LEN = `DPN_LONG_LEN,
  parameter logic [`DPN_ADDR_W-1:0] SHORT_LEN = `DPN_SHORT_LEN,
  parameter logic [`DPN_ADDR_W-1:0] LONG_MASK = `DPN_LONG_MASK,
  parameter logic [6:0] SHORT_MASK = `DPN_SHORT_MASK
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // generator pins, a and b
  input wire logic bit_clk_a_i,
  input wire logic bit_clk_b_i,
  input wire logic sequence_restart_input_a_i,
  input wire logic sequence_restart_input_b_i,
  input wire logic restart_button_a_i,
  input wire logic restart_button_b_i,
  input wire logic [`DPN_POS_W-1:0] sequence_selector_a_i,
  input wire logic [`DPN_POS_W-1:0] sequence_selector_b_i,
  // chip stream consumer handshake
  input wire logic chip_ready_a_i,
  input wire logic chip_ready_b_i,
  output logic chip_stream_out_a_o,
  output logic chip_stream_out_b_o,
  output logic marker_a_o,
  output logic marker_b_o,
  output logic chip_valid_a_o,
  output logic chip_valid_b_o,
  // sequence memory replacement port
  input wire logic prog_we_i,
  input wire logic prog_gen_i,
  input wire logic [`DPN_POS_W-1:0] prog_pos_i,
  input wire logic [`DPN_ADDR_W-1:0] prog_addr_i,
  input wire logic prog_bit_i,
  output logic fill_done_o,
  // exclusive-or units
  input wire logic xor_in_a_a_i,
  input wire logic xor_in_b_a_i,
  input wire logic xor_in_a_b_i,
  input wire logic xor_in_b_b_i,
  output logic xor_logic_a_o,
  output logic xor_logic_b_o,
  output dpn_pkg::dpn_level_t xor_bipolar_a_o,
  output dpn_pkg::dpn_level_t xor_bipolar_b_o
);
  import dpn_pkg::*;

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  // positions 4,5,8,9 share the short period
  function automatic logic is_short(input logic [`DPN_POS_W-1:0] pos);
    is_short = (pos == 4'h4) || (pos == 4'h5) || (pos == 4'h8) || (pos == 4'h9);
  endfunction

  // period length of a position's group
  function automatic logic [`DPN_ADDR_W-1:0] period_len(input logic [`DPN_POS_W-1:0] pos);
    period_len = is_short(pos) ? SHORT_LEN : LONG_LEN;
  endfunction

  // ----------------------------------------------------------------
  // default content fill, shared sequencer writing both memories
  // ----------------------------------------------------------------
  dpn_phase_e phase_ff;
  logic [`DPN_POS_W-1:0] fill_pos_ff; // position being filled
  logic [`DPN_ADDR_W-1:0] fill_addr_ff; // bit being filled
  logic [`DPN_ADDR_W-1:0] lfsr_long_ff; // long maximal generator
  logic [6:0] lfsr_short_ff; // short maximal generator
  logic fill_bit; // bit written during fill
  logic fill_last; // last bit of this position
  logic [`DPN_POS_W-1:0] nxt_pos;

  assign fill_bit = is_short(fill_pos_ff) ? lfsr_short_ff[0] : lfsr_long_ff[0];
  assign fill_last = (fill_addr_ff == period_len(fill_pos_ff) - `DPN_ADDR_ONE);
  assign nxt_pos = fill_pos_ff + `DPN_POS_ONE;

  // walk every position, reseeding so each position is a distinct phase
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      phase_ff <= DPN_ST_FILL;
      fill_pos_ff <= `DPN_POS_ZERO;
      fill_addr_ff <= `DPN_ADDR_ZERO;
      lfsr_long_ff <= `DPN_ADDR_ONE;
      lfsr_short_ff <= 7'h01;
    end else begin
      case (phase_ff)
        DPN_ST_FILL: begin
          if (fill_last) begin
            fill_addr_ff <= `DPN_ADDR_ZERO;
            fill_pos_ff <= nxt_pos;
            // nonzero seed taken from the next position
            lfsr_long_ff <= {{(`DPN_ADDR_W-`DPN_POS_W){1'b0}}, nxt_pos} + `DPN_ADDR_ONE;
            lfsr_short_ff <= {3'h0, nxt_pos} + 7'h01;
            if (fill_pos_ff == `DPN_LAST_POS) begin
              phase_ff <= DPN_ST_RUN;
            end
          end else begin
            fill_addr_ff <= fill_addr_ff + `DPN_ADDR_ONE;
            // galois steps give maximal-length runs
            lfsr_long_ff <= (lfsr_long_ff >> 1) ^ (lfsr_long_ff[0] ? LONG_MASK : '0);
            lfsr_short_ff <= (lfsr_short_ff >> 1) ^ (lfsr_short_ff[0] ? SHORT_MASK : '0);
          end
        end
        DPN_ST_RUN: begin
          phase_ff <= DPN_ST_RUN;
        end
        default: begin
          phase_ff <= DPN_ST_FILL;
        end
      endcase
    end
  end

  // fill status flag
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      fill_done_o <= 1'b0;
    end else begin
      fill_done_o <= (phase_ff == DPN_ST_RUN);
    end
  end

  // ----------------------------------------------------------------
  // pin bundles per channel
  // ----------------------------------------------------------------
  logic [`DPN_SYNC_W-1:0] pins [2]; // raw pins per generator
  logic [1:0] ready_in; // consumer ready per generator

  assign pins[0] = {bit_clk_a_i, sequence_restart_input_a_i, restart_button_a_i,
                    sequence_selector_a_i, xor_in_a_a_i, xor_in_b_a_i};
  assign pins[1] = {bit_clk_b_i, sequence_restart_input_b_i, restart_button_b_i,
                    sequence_selector_b_i, xor_in_a_b_i, xor_in_b_b_i};
  assign ready_in = {chip_ready_b_i, chip_ready_a_i};

  // ----------------------------------------------------------------
  // two identical generators with their own memories
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : gen_ch
    logic [`DPN_SYNC_W-1:0] s1_ff, s2_ff, s3_ff; // three-stage synchroniser
    logic [`DPN_SYNC_W-1:0] filt_ff; // agreed pin levels
    logic [`DPN_ADDR_W-1:0] addr_ff; // next bit to play
    logic mem [`DPN_NUM_POS][2**`DPN_ADDR_W]; // private store
    dpn_chip_s buf_ff [2]; // two-entry buffer
    logic buf_wp_ff, buf_rp_ff; // buffer pointers
    logic [1:0] buf_cnt_ff; // buffer fill level
    logic clk_edge, restart, push, pop, buf_full;
    logic [`DPN_POS_W-1:0] sel;
    logic [`DPN_ADDR_W-1:0] len;
    dpn_chip_s out_ff; // output chip register of this generator
    logic out_valid_ff; // output chip valid of this generator
    logic xor_ff; // registered xor result of this channel

    // a level is accepted once the second and third stages agree
    always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
        s1_ff <= '0;
        s2_ff <= '0;
        s3_ff <= '0;
        filt_ff <= '0;
      end else begin
        s1_ff <= pins[g];
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
        filt_ff <= (s2_ff & s3_ff) | (filt_ff & (s2_ff | s3_ff));
      end
    end

    // rising edge of the agreed bit clock
    assign clk_edge = (s2_ff[`DPN_SB_CLK] & s3_ff[`DPN_SB_CLK]) & ~filt_ff[`DPN_SB_CLK];
    assign restart = filt_ff[`DPN_SB_RST] | filt_ff[`DPN_SB_BTN];
    // out-of-range selector settings play position zero
    assign sel = (filt_ff[`DPN_SB_SEL_HI:`DPN_SB_SEL_LO] > `DPN_LAST_POS) ? `DPN_POS_ZERO
               : filt_ff[`DPN_SB_SEL_HI:`DPN_SB_SEL_LO];
    assign len = period_len(sel);
    assign buf_full = (buf_cnt_ff == 2'h2);
    // a full buffer holds the generator, so no chip is lost
    assign push = clk_edge & ~restart & ~buf_full & (phase_ff == DPN_ST_RUN);
    assign pop = (buf_cnt_ff != 2'h0) & (~out_valid_ff | ready_in[g]);

    // memory writes: default fill, then the replacement port
    always_ff @(posedge clk_i) begin
      if (phase_ff == DPN_ST_FILL) begin
        mem[fill_pos_ff][fill_addr_ff] <= fill_bit;
      end else if (prog_we_i && (prog_gen_i == 1'(g)) && (prog_pos_i <= `DPN_LAST_POS)) begin
        mem[prog_pos_i][prog_addr_i] <= prog_bit_i;
      end
    end

    // play pointer: restart holds first bit, wrap after the last
    always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
        addr_ff <= `DPN_ADDR_ZERO;
      end else if (restart) begin
        addr_ff <= `DPN_ADDR_ZERO;
      end else if (push) begin
        if (addr_ff >= len - `DPN_ADDR_ONE) begin
          addr_ff <= `DPN_ADDR_ZERO;
        end else begin
          addr_ff <= addr_ff + `DPN_ADDR_ONE;
        end
      end
    end

    // buffer storage and pointers
    always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
        buf_wp_ff <= 1'b0;
        buf_rp_ff <= 1'b0;
        buf_cnt_ff <= 2'h0;
        buf_ff[0] <= '0;
        buf_ff[1] <= '0;
      end else begin
        if (push) begin
          buf_ff[buf_wp_ff].seq <= mem[sel][addr_ff];
          buf_ff[buf_wp_ff].mark <= (addr_ff == `DPN_ADDR_ZERO);
          buf_wp_ff <= ~buf_wp_ff;
        end
        if (pop) begin
          buf_rp_ff <= ~buf_rp_ff;
        end
        buf_cnt_ff <= buf_cnt_ff + {1'b0, push} - {1'b0, pop};
      end
    end

    // output chip register, held until the consumer takes it
    always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
        out_ff <= '0;
        out_valid_ff <= 1'b0;
      end else if (pop) begin
        out_ff <= buf_ff[buf_rp_ff];
        out_valid_ff <= 1'b1;
      end else if (ready_in[g]) begin
        out_valid_ff <= 1'b0;
        out_ff.mark <= 1'b0;
      end
    end

    // exclusive-or unit of this channel
    always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
        xor_ff <= 1'b0;
      end else begin
        xor_ff <= filt_ff[`DPN_SB_XA] ^ filt_ff[`DPN_SB_XB];
      end
    end
  end

  // ----------------------------------------------------------------
  // output mapping, all from registers
  // ----------------------------------------------------------------
  assign chip_stream_out_a_o = gen_ch[0].out_ff.seq;
  assign chip_stream_out_b_o = gen_ch[1].out_ff.seq;
  assign marker_a_o = gen_ch[0].out_ff.mark;
  assign marker_b_o = gen_ch[1].out_ff.mark;
  assign chip_valid_a_o = gen_ch[0].out_valid_ff;
  assign chip_valid_b_o = gen_ch[1].out_valid_ff;
  assign xor_logic_a_o = gen_ch[0].xor_ff;
  assign xor_logic_b_o = gen_ch[1].xor_ff;

  // bipolar levels follow the logic results in the same cycle
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      xor_bipolar_a_o <= `DPN_LEVEL_NEG;
      xor_bipolar_b_o <= `DPN_LEVEL_NEG;
    end else begin
      xor_bipolar_a_o <= (gen_ch[0].filt_ff[`DPN_SB_XA] ^ gen_ch[0].filt_ff[`DPN_SB_XB])
                         ? `DPN_LEVEL_POS : `DPN_LEVEL_NEG;
      xor_bipolar_b_o <= (gen_ch[1].filt_ff[`DPN_SB_XA] ^ gen_ch[1].filt_ff[`DPN_SB_XB])
                         ? `DPN_LEVEL_POS : `DPN_LEVEL_NEG;
    end
  end
endmodule

// ===== dpn_source_assertions.sv
// port checker for the dual sequence source, bound to the top module
`timescale 1ns/1ps
`include "dpn_defs.svh"
module dpn_source_assertions (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // chip streams
  input wire logic chip_ready_a_i,
  input wire logic chip_ready_b_i,
  input wire logic chip_valid_a_o,
  input wire logic chip_valid_b_o,
  input wire logic chip_stream_out_a_o,
  input wire logic chip_stream_out_b_o,
  input wire logic marker_a_o,
  input wire logic marker_b_o,
  input wire logic fill_done_o,
  // exclusive-or units
  input wire logic xor_in_a_a_i,
  input wire logic xor_in_b_a_i,
  input wire logic xor_in_a_b_i,
  input wire logic xor_in_b_b_i,
  input wire logic xor_logic_a_o,
  input wire logic xor_logic_b_o,
  input wire dpn_pkg::dpn_level_t xor_bipolar_a_o,
  input wire dpn_pkg::dpn_level_t xor_bipolar_b_o
);
  import dpn_pkg::*;
  // ----------------------------------------------------------------
  // properties, all on the system clock
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // bipolar code always mirrors the logic result
  property p_bip_a;
    xor_bipolar_a_o == (xor_logic_a_o ? `DPN_LEVEL_POS : `DPN_LEVEL_NEG);
  endproperty
  a_bip_a: assert property (p_bip_a) else $error("bipolar a disagrees");
  property p_bip_b;
    xor_bipolar_b_o == (xor_logic_b_o ? `DPN_LEVEL_POS : `DPN_LEVEL_NEG);
  endproperty
  a_bip_b: assert property (p_bip_b) else $error("bipolar b disagrees");
  // steady inputs settle into their exclusive-or
  property p_xor_a;
    (rstn_i && $stable(xor_in_a_a_i) && $stable(xor_in_b_a_i)) [*6]
      |-> xor_logic_a_o == (xor_in_a_a_i ^ xor_in_b_a_i);
  endproperty
  a_xor_a: assert property (p_xor_a) else $error("xor a wrong");
  property p_xor_b;
    (rstn_i && $stable(xor_in_a_b_i) && $stable(xor_in_b_b_i)) [*6]
      |-> xor_logic_b_o == (xor_in_a_b_i ^ xor_in_b_b_i);
  endproperty
  a_xor_b: assert property (p_xor_b) else $error("xor b wrong");
  // a marker only ever rides on a valid chip
  property p_mark_a;
    marker_a_o |-> chip_valid_a_o;
  endproperty
  a_mark_a: assert property (p_mark_a) else $error("marker a without chip");
  property p_mark_b;
    marker_b_o |-> chip_valid_b_o;
  endproperty
  a_mark_b: assert property (p_mark_b) else $error("marker b without chip");
  // leaving reset both chip valids and fill done are cleared
  property p_rst_out;
    $rose(rstn_i) |-> !chip_valid_a_o && !chip_valid_b_o && !fill_done_o;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not cleared");
  // a stalled chip stands unchanged
  property p_hold_a;
    chip_valid_a_o && !chip_ready_a_i
      |=> chip_valid_a_o && $stable(chip_stream_out_a_o) && $stable(marker_a_o);
  endproperty
  a_hold_a: assert property (p_hold_a) else $error("chip a dropped");
  property p_hold_b;
    chip_valid_b_o && !chip_ready_b_i
      |=> chip_valid_b_o && $stable(chip_stream_out_b_o) && $stable(marker_b_o);
  endproperty
  a_hold_b: assert property (p_hold_b) else $error("chip b dropped");
  // no chip before the store is filled
  property p_no_early;
    !fill_done_o |-> !chip_valid_a_o && !chip_valid_b_o;
  endproperty
  a_no_early: assert property (p_no_early) else $error("chip before fill");
  // fill completion stays up
  property p_done_keep;
    fill_done_o |=> fill_done_o;
  endproperty
  a_done_keep: assert property (p_done_keep) else $error("fill done fell");
endmodule
bind dpn_source dpn_source_assertions u_chk (
  .clk_i(clk_i), .rstn_i(rstn_i), .chip_ready_a_i(chip_ready_a_i),
  .chip_ready_b_i(chip_ready_b_i), .chip_valid_a_o(chip_valid_a_o),
  .chip_valid_b_o(chip_valid_b_o), .chip_stream_out_a_o(chip_stream_out_a_o),
  .chip_stream_out_b_o(chip_stream_out_b_o), .marker_a_o(marker_a_o),
  .marker_b_o(marker_b_o), .fill_done_o(fill_done_o), .xor_in_a_a_i(xor_in_a_a_i),
  .xor_in_b_a_i(xor_in_b_a_i), .xor_in_a_b_i(xor_in_a_b_i),
  .xor_in_b_b_i(xor_in_b_b_i), .xor_logic_a_o(xor_logic_a_o),
  .xor_logic_b_o(xor_logic_b_o), .xor_bipolar_a_o(xor_bipolar_a_o),
  .xor_bipolar_b_o(xor_bipolar_b_o)
);

// ===== dpn_partner.sv
// far side model: bit clock source and chip consumer
`timescale 1ns/1ps
module dpn_partner (
  // clock
  input wire logic clk_i,
  // one bit period request and consumer stall
  input wire logic go_i,
  input wire logic stall_i,
  // towards the source
  output logic bit_clk_o,
  output logic ready_o
);
  logic [3:0] cnt_ff = 4'h0;
  // one request gives four cycles high then four low; idle low
  always @(negedge clk_i) begin
    if (go_i) begin
      cnt_ff <= 4'h8;
    end else if (cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff - 4'h1;
    end
  end
  assign bit_clk_o = cnt_ff > 4'h4;
  // consumer stalls at random
  assign ready_o = !stall_i;
endmodule

// ===== tb.sv
// self-checking bench of the dual sequence source
`timescale 1ns/1ps
`include "dpn_defs.svh"
module tb;
  import dpn_pkg::*;
  localparam logic [13:0] LLEN = 14'h001F;
  localparam logic [13:0] SLEN = 14'h0007;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [1:0] go = 2'h0;
  logic [1:0] stall = 2'h0;
  logic [3:0] rs = 4'h0;
  logic [3:0] sel_a = 4'h0;
  logic [3:0] sel_b = 4'h4;
  logic [3:0] xin = 4'h0;
  logic [19:0] pg = 20'h00000;
  logic we = 1'b0;
  logic [7:0] lfsr_ff = 8'h5A;
  wire bck_a, bck_b, rdy_a, rdy_b, so_a, so_b, mk_a, mk_b, v_a, v_b, done, xl_a, xl_b;
  dpn_level_t xp_a, xp_b;
  logic ma [0:30];
  logic mb [0:6];
  dpn_chip_s qa [$];
  dpn_chip_s qb [$];
  int ia = 0;
  int ib = 0;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  dpn_source #(.LONG_LEN(LLEN), .SHORT_LEN(SLEN)) u_dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .bit_clk_a_i(bck_a), .bit_clk_b_i(bck_b),
    .sequence_restart_input_a_i(rs[3]), .sequence_restart_input_b_i(rs[2]),
    .restart_button_a_i(rs[1]), .restart_button_b_i(rs[0]),
    .sequence_selector_a_i(sel_a), .sequence_selector_b_i(sel_b),
    .chip_ready_a_i(rdy_a), .chip_ready_b_i(rdy_b), .chip_stream_out_a_o(so_a),
    .chip_stream_out_b_o(so_b), .marker_a_o(mk_a), .marker_b_o(mk_b),
    .chip_valid_a_o(v_a), .chip_valid_b_o(v_b), .prog_we_i(we), .prog_gen_i(pg[19]),
    .prog_pos_i(pg[18:15]), .prog_addr_i(pg[14:1]), .prog_bit_i(pg[0]),
    .fill_done_o(done), .xor_in_a_a_i(xin[3]), .xor_in_b_a_i(xin[2]),
    .xor_in_a_b_i(xin[1]), .xor_in_b_b_i(xin[0]), .xor_logic_a_o(xl_a),
    .xor_logic_b_o(xl_b), .xor_bipolar_a_o(xp_a), .xor_bipolar_b_o(xp_b)
  );
  dpn_partner u_far_a (.clk_i(clk_i), .go_i(go[1]), .stall_i(stall[1]),
    .bit_clk_o(bck_a), .ready_o(rdy_a));
  dpn_partner u_far_b (.clk_i(clk_i), .go_i(go[0]), .stall_i(stall[0]),
    .bit_clk_o(bck_b), .ready_o(rdy_b));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // compare and count
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // verdict and end of run
  task automatic tally_and_finish();
    if (mismatches == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // logic result with its bipolar code
  function automatic logic [3:0] lvl(logic b);
    return {b, b ? `DPN_LEVEL_POS : `DPN_LEVEL_NEG};
  endfunction
  // n bit periods on both generators, expectation noted first
  task automatic play(int n);
    for (int i = 0; i < n; i++) begin
      qa.push_back(dpn_chip_s'{ma[ia], ia == 0});
      // b on position 0 plays the inverted long pattern written into its own store
      qb.push_back((sel_b == 4'h0) ? dpn_chip_s'{~ma[ib], ib == 0}
                                   : dpn_chip_s'{mb[ib], ib == 0});
      ia = (ia + 1) % int'(LLEN);
      ib = (ib + 1) % int'((sel_b == 4'h0) ? LLEN : SLEN);
      go <= 2'h3;
      @(negedge clk_i);
      go <= 2'h0;
      repeat (7) @(negedge clk_i);
    end
  endtask
  // one write into a sequence memory
  task automatic prog(logic g, logic [3:0] pos, int a, logic b);
    pg <= {g, pos, a[13:0], b};
    we <= 1'b1;
    @(negedge clk_i);
    we <= 1'b0;
    @(negedge clk_i);
  endtask
  // ----------------------------------------------------------------
  // clock, random source, watchdog and output monitor
  // ----------------------------------------------------------------
  initial forever #5 clk_i = ~clk_i;
  always @(negedge clk_i) begin
    lfsr_ff <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
    stall <= lfsr_ff[1:0];
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      tally_and_finish();
    end
    if (v_a === 1'b1 && rdy_a === 1'b1) begin
      check("chip a", {6'h00, so_a, mk_a}, {6'h00, qa.pop_front()});
    end
    if (v_b === 1'b1 && rdy_b === 1'b1) begin
      check("chip b", {6'h00, so_b, mk_b}, {6'h00, qb.pop_front()});
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(negedge clk_i);
    rstn_i <= 1'b1;
    for (int k = 0; k < 400 && done !== 1'b1; k++) @(negedge clk_i);
    check("fill done", {7'h00, done}, 8'h01);
    for (int k = 0; k < 31; k++) begin
      ma[k] = lfsr_ff[2];
      prog(1'b0, 4'h0, k, ma[k]);
      prog(1'b1, 4'h0, k, ~ma[k]);
    end
    for (int k = 0; k < 7; k++) begin
      mb[k] = lfsr_ff[3];
      prog(1'b1, 4'h4, k, mb[k]);
    end
    play(40);
    // restart a by pin and b by button, a to an out-of-range position, b to long position 0
    rs <= 4'h9;
    sel_a <= 4'hC;
    sel_b <= 4'h0;
    repeat (10) @(negedge clk_i);
    rs <= 4'h0;
    repeat (8) @(negedge clk_i);
    ia = 0;
    ib = 0;
    play(12);
    for (int k = 0; k < 16; k++) begin
      xin <= k[3:0];
      repeat (8) @(negedge clk_i);
      check("xor", {xl_a, xp_a, xl_b, xp_b}, {lvl(k[3] ^ k[2]), lvl(k[1] ^ k[0])});
    end
    check("left", 8'(qa.size() + qb.size()), 8'h00);
    tally_and_finish();
  end
endmodule
